/* rtl/rsc_pkg.sv */
/*
  Package for the reset source combiner: register offset, bit positions,
  reset values and source bundle type.
  Assumes a single 25 MHz system clock and an AHB-Lite register bus.
*/
package rsc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] RSC_CAUSE_OFS = 12'h000;
  localparam logic [11:0] RSC_STATE_OFS = 12'h004;
  localparam int RSC_REG_W = 16;

  // ----------------------------------------
  // Bit positions of the cause register
  // ----------------------------------------
  localparam int RSC_POR_BIT = 0;
  localparam int RSC_BOR_BIT = 1;
  localparam int RSC_IDLE_BIT = 2;
  localparam int RSC_SLEEP_BIT = 3;
  localparam int RSC_WATCHDOG_TIMEOUT_FLAG_BIT = 4;
  localparam int RSC_SWDT_BIT = 5;
  localparam int RSC_SWR_BIT = 6;
  localparam int RSC_EXT_BIT = 7;
  localparam int RSC_VREG_BIT = 8;
  localparam int RSC_CM_BIT = 9;
  localparam int RSC_ILL_BIT = 14;
  localparam int RSC_TRAP_BIT = 15;

  // Implemented bits; 13..10 read as zero
  localparam logic [15:0] RSC_IMPL_MASK = 16'hC3FF;
  // Value after power-on: power-on and brown-out flags set
  localparam logic [15:0] RSC_POR_VALUE = 16'h0003;

  // ----------------------------------------
  // Bus encodings
  // ----------------------------------------
  localparam logic [1:0] RSC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] RSC_HTRANS_SEQ = 2'h3;

  // Reset and wake sources, all active high, one clock wide or longer
  typedef struct packed {
    logic power_on;
    logic brownout;
    logic master_clear;
    logic reset_instr;
    logic watchdog_timeout;
    logic config_mismatch;
    logic trap_conflict;
    logic illegal_opcode;
    logic uninit_wreg;
    logic security;
    logic sleep_wake;
    logic idle_wake;
  } rsc_sources_t;

endpackage

/* rtl/rsc_reset_combiner.sv */
/*
  Reset source combiner: ORs all reset sources into one master reset and
  keeps the software-visible reset cause and control register.
  Assumes sources are synchronous to clock_i and that power-on is held
  active for at least one clock edge while the clock runs.
*/
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_combiner #(
  parameter int REG_W = rsc_pkg::RSC_REG_W,
  parameter int ADDR_W = $bits(rsc_pkg::RSC_CAUSE_OFS)
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire rsc_pkg::rsc_sources_t sources_i,
  input wire logic fuse_watchdog_enable_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic master_reset_o,
  output logic watchdog_enable_o,
  output logic regulator_sleep_sel_o
);
  import rsc_pkg::*;

  // ----------------------------------------
  // Sizes and elaboration checks
  // ----------------------------------------
  localparam int BUS_W = $bits(hwdata_i);

  // Flag positions are fixed; another width would move them away from
  // where software looks for them.
  if (REG_W != RSC_REG_W) begin : g_bad_reg_w
    $error("register width must match the cause layout");
  end

  // The decoder compares the low address bits with the offsets as-is.
  if (ADDR_W != $bits(RSC_CAUSE_OFS)) begin : g_bad_addr_w
    $error("address width must match the register offsets");
  end

  // The cause word is returned in the low half of a bus word.
  if (REG_W > BUS_W) begin : g_bad_bus_w
    $error("register wider than the data bus");
  end

  // Power-on must not load a bit that always reads as zero.
  if ((RSC_POR_VALUE & ~RSC_IMPL_MASK) != '0) begin : g_bad_por
    $error("power-on value touches unimplemented bits");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Word decode shared by the write strobe and the read mux
  function automatic logic word_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] ofs
  );
    word_hit = (addr == ofs);
  endfunction

  // One event placed at its flag position, zero elsewhere
  function automatic logic [REG_W-1:0] at_bit(
    input int pos,
    input logic value
  );
    at_bit = '0;
    at_bit[pos] = value;
  endfunction

  // Only NONSEQ and SEQ carry a transfer; IDLE and BUSY are ignored.
  function automatic logic trans_active(input logic [1:0] trans);
    trans_active = (trans == RSC_HTRANS_NONSEQ) ||
                   (trans == RSC_HTRANS_SEQ);
  endfunction

  // Every event flag must land on an implemented bit.
  function automatic logic flag_ok(input int pos);
    flag_ok = (pos < REG_W) && RSC_IMPL_MASK[pos];
  endfunction

  if (!(flag_ok(RSC_POR_BIT) && flag_ok(RSC_BOR_BIT) &&
        flag_ok(RSC_IDLE_BIT) && flag_ok(RSC_SLEEP_BIT) &&
        flag_ok(RSC_WATCHDOG_TIMEOUT_FLAG_BIT) && flag_ok(RSC_SWR_BIT) &&
        flag_ok(RSC_EXT_BIT) && flag_ok(RSC_CM_BIT) &&
        flag_ok(RSC_ILL_BIT) && flag_ok(RSC_TRAP_BIT))) begin : g_bad_map
    $error("an event flag sits on an unimplemented bit");
  end

  // ----------------------------------------
  // Source taps
  // ----------------------------------------
  wire logic src_por;
  assign src_por = sources_i.power_on;
  wire logic src_bor;
  assign src_bor = sources_i.brownout;
  wire logic src_pin;
  assign src_pin = sources_i.master_clear;
  wire logic src_instr;
  assign src_instr = sources_i.reset_instr;
  wire logic src_wdt;
  assign src_wdt = sources_i.watchdog_timeout;
  wire logic src_cfg;
  assign src_cfg = sources_i.config_mismatch;
  wire logic src_trap;
  assign src_trap = sources_i.trap_conflict;

  wire logic src_opcode;
  assign src_opcode = sources_i.illegal_opcode;
  wire logic src_wreg;
  assign src_wreg = sources_i.uninit_wreg;
  wire logic src_secure;
  assign src_secure = sources_i.security;

  // Wake events are not resets; they only leave a trace in the register.
  wire logic src_sleep;
  assign src_sleep = sources_i.sleep_wake;
  wire logic src_idle;
  assign src_idle = sources_i.idle_wake;

  // ----------------------------------------
  // Reset combining
  // ----------------------------------------
  // The three illegal conditions share one flag and one reset path.
  wire logic any_illegal;
  assign any_illegal = src_opcode |
                       src_wreg |
                       src_secure;

  wire logic any_source;
  assign any_source = src_por |
                      src_bor |
                      src_pin |
                      src_instr |
                      src_wdt |
                      src_cfg |
                      src_trap |
                      any_illegal;

  // Registered so the master reset is glitch free toward the core; the
  // price is one cycle between a source and the reset it causes.
  logic master_reset;
  wire logic next_master_reset;
  assign next_master_reset = any_source;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      master_reset <= 1'b1;
    end else begin
      master_reset <= next_master_reset;
    end
  end
  assign master_reset_o = master_reset;

  // ----------------------------------------
  // Hardware events per flag
  // ----------------------------------------
  wire logic [REG_W-1:0] hw_set;
  assign hw_set = at_bit(RSC_TRAP_BIT, src_trap) |
                  at_bit(RSC_ILL_BIT, any_illegal) |
                  at_bit(RSC_CM_BIT, src_cfg) |
                  at_bit(RSC_EXT_BIT, src_pin) |
                  at_bit(RSC_SWR_BIT, src_instr) |
                  at_bit(RSC_WATCHDOG_TIMEOUT_FLAG_BIT, src_wdt) |
                  at_bit(RSC_SLEEP_BIT, src_sleep) |
                  at_bit(RSC_IDLE_BIT, src_idle) |
                  at_bit(RSC_BOR_BIT, src_bor) |
                  at_bit(RSC_POR_BIT, src_por);

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  // Zero wait states: every transfer is answered in its data phase.
  wire logic take;
  assign take = hsel_i & hready_i & trans_active(htrans_i);
  wire logic take_write;
  assign take_write = take & hwrite_i;
  wire logic take_read;
  assign take_read = take & !hwrite_i;
  wire logic [ADDR_W-1:0] addr_a;
  assign addr_a = haddr_i[ADDR_W-1:0];

  // Address phase of a write, carried into its data phase
  logic wr_pend;
  wire logic next_wr_pend;
  assign next_wr_pend = take_write;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
    end
  end

  logic [ADDR_W-1:0] wr_addr;
  wire logic [ADDR_W-1:0] next_wr_addr;
  assign next_wr_addr = take ? addr_a : wr_addr;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wr_addr <= '0;
    end else begin
      wr_addr <= next_wr_addr;
    end
  end

  // Writes to the status word or to unmapped words are dropped.
  wire logic sw_write;
  assign sw_write = wr_pend & word_hit(wr_addr, RSC_CAUSE_OFS);
  wire logic [REG_W-1:0] sw_data;
  assign sw_data = hwdata_i[REG_W-1:0] & RSC_IMPL_MASK;

  // ----------------------------------------
  // Cause and control register
  // ----------------------------------------
  // Per flag: power-on wins over all, then a hardware event wins over a
  // software clear in the same cycle, so that only a reset coinciding with power-on goes unrecorded.
  // Software writes only store; they never reach any_source.
  logic [REG_W-1:0] cause;
  for (genvar b = 0; b < REG_W; b++) begin : g_flag
    wire logic kept;
    assign kept = sw_write ? sw_data[b] : cause[b];
    wire logic next_flag;
    assign next_flag = src_por ? RSC_POR_VALUE[b] :
                       (kept | hw_set[b]);
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        cause[b] <= RSC_POR_VALUE[b];
      end else begin
        cause[b] <= next_flag;
      end
    end
  end

  assign regulator_sleep_sel_o = cause[RSC_VREG_BIT];
  // The fuse overrides software: the watchdog cannot be turned off then.
  assign watchdog_enable_o = fuse_watchdog_enable_i |
                             cause[RSC_SWDT_BIT];

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  wire logic [BUS_W-1:0] cause_word;
  assign cause_word = BUS_W'(cause);
  // Status word: bit 0 master reset, bit 1 watchdog enable
  wire logic [BUS_W-1:0] state_word;
  assign state_word = BUS_W'({watchdog_enable_o, master_reset});
  wire logic [BUS_W-1:0] rd_next;
  assign rd_next = word_hit(addr_a, RSC_CAUSE_OFS) ? cause_word :
                   word_hit(addr_a, RSC_STATE_OFS) ? state_word :
                   '0;

  // Read data is held until the next read, not only for its data phase.
  wire logic [BUS_W-1:0] next_hrdata;
  assign next_hrdata = take_read ? rd_next : hrdata_o;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      hrdata_o <= '0;
    end else begin
      hrdata_o <= next_hrdata;
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

endmodule // rsc_reset_combiner

`default_nettype wire

/* bench/rsc_chk.sv */
/* Port checker for the reset source combiner.
   Assumes it is bound to rsc_reset_combiner, and that the bench writes
   only the cause register. */
`timescale 1ns/1ps
`default_nettype none
module rsc_chk (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire rsc_pkg::rsc_sources_t sources_i,
  input wire logic fuse_watchdog_enable_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic master_reset_o,
  input wire logic watchdog_enable_o,
  input wire logic regulator_sleep_sel_o
);
  import rsc_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic wr_a = hsel_i && htrans_i[1] && hwrite_i;
  // Wake events are not resets, so they stay out of this
  wire logic rst_any = sources_i.power_on | sources_i.brownout |
    sources_i.master_clear | sources_i.reset_instr |
    sources_i.watchdog_timeout | sources_i.config_mismatch |
    sources_i.trap_conflict | sources_i.illegal_opcode |
    sources_i.uninit_wreg | sources_i.security;
  // Write address phase, then a data phase not overridden by power-on
  sequence s_wr; wr_a ##1 !sources_i.power_on; endsequence
  sequence s_idle; !wr_a ##1 !sources_i.power_on; endsequence
  a_src_reset: assert property (rst_any |=> master_reset_o)
    else $error("source did not raise master reset");
  a_quiet_run: assert property (!rst_any |=> !master_reset_o)
    else $error("master reset without a source");
  a_fuse_wdt: assert property (fuse_watchdog_enable_i |-> watchdog_enable_o)
    else $error("fuse did not force watchdog on");
  a_por_vreg: assert property (sources_i.power_on |=> !regulator_sleep_sel_o)
    else $error("power-on left regulator select set");
  a_por_wdt: assert property (sources_i.power_on |=>
    watchdog_enable_o == fuse_watchdog_enable_i) else $error("power-on wdt");
  a_vreg_hold: assert property (s_idle |=> $stable(regulator_sleep_sel_o))
    else $error("regulator select moved without a write");
  a_vreg_write: assert property (s_wr |=>
    regulator_sleep_sel_o == $past(hwdata_i[8])) else $error("vreg write");
  a_swdt_write: assert property (s_wr |=> watchdog_enable_o ==
    ($past(hwdata_i[5]) | fuse_watchdog_enable_i)) else $error("swdt write");
endmodule // rsc_chk
`default_nettype wire

/* bench/rsc_src_model.sv */
/* Source model: pulses one reset or wake source for one cycle.
   Assumes the bench picks the source by index, 0 being power-on. */
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [3:0] sel_i,
  output var rsc_pkg::rsc_sources_t src_o
);
  import rsc_pkg::*;
  always_ff @(posedge clock_i) begin
    src_o <= go_i ? rsc_sources_t'(12'h800 >> sel_i) : '0;
  end
endmodule // rsc_src_model
`default_nettype wire

/* bench/tb.sv */
/* Bench for the reset source combiner over AHB-Lite.
   Assumes a zero-wait slave and the source model beside it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsc_pkg::*;
  logic clock_i = 0, rst_b_i = 0, fuse = 0, hsel = 0, hwrite = 0, go = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [3:0] sel = 0;
  logic hrdy, hresp, mrst, wdt, vreg;
  rsc_sources_t src;
  int fails = 0, n_tests = 0;
  int bits[12] = '{0, 1, 7, 6, 4, 9, 15, 14, 14, 14, 3, 2};
  rsc_src_model u_src (.clock_i(clock_i), .go_i(go), .sel_i(sel),
    .src_o(src));
  rsc_reset_combiner dut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .sources_i(src), .fuse_watchdog_enable_i(fuse), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .master_reset_o(mrst),
    .watchdog_enable_o(wdt), .regulator_sleep_sel_o(vreg));
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (hrdy !== 1'b1 && n < 9);
    if (hrdy !== 1'b1) begin
      fails++;
      tally_and_finish;
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= RSC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task pulse(input logic [3:0] s);
    go <= 1'b1;
    sel <= s;
    @(posedge clock_i);
    go <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
  task t_powerup;
    xfer(1'b0, 32'h0, 32'h0);
    chk(r, 32'h3);
    chk({31'h0, hresp}, 32'h0);
    xfer(1'b0, 32'h10, 32'h0);
    chk(r, 32'h0);
  endtask
  task t_sources;
    logic [31:0] e;
    e = 32'h0;
    xfer(1'b1, 32'h0, 32'h0);
    for (int i = 1; i < 12; i++) begin
      pulse(i[3:0]);
      e[bits[i]] = 1'b1;
      xfer(1'b0, 32'h0, 32'h0);
      chk(r, e);
    end
    pulse(4'h0);
    xfer(1'b0, 32'h0, 32'h0);
    chk(r, 32'h3);
  endtask
  task t_write;
    xfer(1'b1, 32'h0, 32'hFFFF_FFFF);
    repeat (2) @(posedge clock_i);
    chk({31'h0, mrst}, 32'h0);
    xfer(1'b0, 32'h0, 32'h0);
    chk(r, 32'hC3FF);
    chk({30'h0, wdt, vreg}, 32'h3);
    xfer(1'b1, 32'h0, 32'h0);
    @(posedge clock_i);
    chk({30'h0, wdt, vreg}, 32'h0);
    fuse <= 1'b1;
    xfer(1'b0, {20'h0, RSC_STATE_OFS}, 32'h0);
    chk(r, 32'h2);
  endtask
  initial forever #20 clock_i = ~clock_i;
  initial begin
    repeat (20) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_powerup;
    t_sources;
    t_write;
    tally_and_finish;
  end
endmodule // tb
bind rsc_reset_combiner rsc_chk u_chk (.clock_i(clock_i),
  .rst_b_i(rst_b_i), .sources_i(sources_i),
  .fuse_watchdog_enable_i(fuse_watchdog_enable_i), .hsel_i(hsel_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i),
  .master_reset_o(master_reset_o), .watchdog_enable_o(watchdog_enable_o),
  .regulator_sleep_sel_o(regulator_sleep_sel_o));
`default_nettype wire
